// ===== rtl/bsp_pkg.sv
package bsp_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------

  // Data width of the 36-bit configuration that this model builds.
  localparam int BSP_DW = 36;
  // Address width tied to the data width.
  localparam int BSP_AW = (BSP_DW <= 9) ? 20 : (BSP_DW == 18) ? 19 : 18;
  // Words per burst, one from each array.
  localparam int BSP_BURST = 4;
  // Number of write select lanes.
  localparam int BSP_LANES = (BSP_DW == 8) ? 2 : BSP_DW / 9;
  // Bits per lane.
  localparam int BSP_LANE_W = (BSP_DW == 8) ? 4 : 9;
  // Index bits of each array held in simulation, 64 words; the full depth is 2**BSP_AW.
  localparam int BSP_DEPTH_BITS = 6;
  // Read latency in half cycles, normal and dll-off modes.
  localparam logic [2:0] BSP_LAT_DLL = 3'h3;
  localparam logic [2:0] BSP_LAT_NODLL = 3'h2;
  // Request FIFO depth and reset values.
  localparam int BSP_FIFO_DEPTH = 8;
  localparam logic [1:0] BSP_BEAT_RST = 2'h0;

  // Beat counter states.
  typedef enum logic [1:0] {
    BSP_IDLE = 2'b00,
    BSP_BUSY = 2'b01
  } bsp_state_t;

  // Expand the active-low lane selects into a bit mask, ones where written.
  function automatic logic [BSP_DW-1:0] bsp_mask(input logic [BSP_LANES-1:0] sel_n);
    logic [BSP_DW-1:0] m;
    m = '0;
    for (int i = 0; i < BSP_LANES; i++) begin
      m[i*BSP_LANE_W +: BSP_LANE_W] = {BSP_LANE_W{~sel_n[i]}};
    end
    return m;
  endfunction : bsp_mask

endpackage : bsp_pkg

// ===== rtl/bsp_if.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Pin bundle between controller and memory. Both input clock edges
// are modelled as one-cycle enables of mclk: k_rise and kn_rise
// alternate, c_rise and cn_rise likewise for the output clock.
// ------------------------------------------------------------------
interface bsp_if;
  import bsp_pkg::*;
  logic k_rise; // Positive input clock edge enable.
  logic kn_rise; // Negative input clock edge enable.
  logic c_rise; // Positive output clock edge enable.
  logic cn_rise; // Negative output clock edge enable.
  logic single_clk; // High selects single clock mode.
  logic dll_disable_n; // Low selects dll-off mode.
  logic read_port_sel_n; // Read port select, active low.
  logic write_port_sel_n; // Write port select, active low.
  logic [BSP_AW-1:0] addr; // Shared address bus.
  logic [BSP_DW-1:0] wdata; // Write data bus.
  logic [BSP_LANES-1:0] byte_write_sel_n; // Lane write selects, active low.
  logic [BSP_DW-1:0] rdata; // Read data out.
  logic rdata_oe; // High while the memory drives rdata.
  logic [1:0] echo_clk_pair; // Echo clock pair, bit 0 positive.

  modport ctrl (
    output k_rise, kn_rise, c_rise, cn_rise, single_clk, dll_disable_n,
    output read_port_sel_n, write_port_sel_n, addr, wdata, byte_write_sel_n,
    input rdata, rdata_oe, echo_clk_pair
  );
  modport mem (
    input k_rise, kn_rise, c_rise, cn_rise, single_clk, dll_disable_n,
    input read_port_sel_n, write_port_sel_n, addr, wdata, byte_write_sel_n,
    output rdata, rdata_oe, echo_clk_pair
  );
endinterface : bsp_if

// ===== rtl/bsp_fifo.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides.
// ------------------------------------------------------------------
module bsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
  logic [PW-1:0] wp; // Write pointer.
  logic [PW-1:0] rp; // Read pointer.
  logic [PW:0] cnt; // Occupancy.
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Ready while at least one slot is free, an empty queue included.
  assign in_ready = (cnt < (PW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];

  // Pointers and count; storage has no reset, it needs none.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= PW'(wp + 1'b1);
      if (pop) rp <= PW'(rp + 1'b1);
      cnt <= (PW+1)'(cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
    end
  end

  // Data write.
  always_ff @(posedge mclk) begin
    if (push) mem[wp] <= in_data;
  end
endmodule : bsp_fifo

// ===== rtl/bsp_mem.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Memory end: four arrays, burst-of-four read and write ports.
// ------------------------------------------------------------------
module bsp_mem
  import bsp_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  bsp_if.mem pins
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Four arrays; each burst address picks one word from each.
  logic [BSP_DW-1:0] arr [BSP_BURST][2**BSP_DEPTH_BITS];
  logic [BSP_AW-1:0] waddr; // Latched write address.
  logic [1:0] wbeat; // Write beat index.
  logic wbusy; // Write burst in progress.
  logic [BSP_AW-1:0] raddr; // Latched read address.
  logic [2:0] rwait; // Half cycles left before the first read beat.
  logic rpend; // Read accepted, waiting for latency.
  logic [1:0] rbeat; // Read beat index.
  logic rout; // Read beats being driven.
  logic [BSP_DW-1:0] rdata_q; // Registered read data.
  logic oe_q; // Registered output enable.
  logic [1:0] echo_q; // Registered echo clocks.

  wire edge_k = pins.k_rise || pins.kn_rise; // Any input clock edge.
  // Output edges come from the input clocks in single clock mode.
  wire out_pos = pins.single_clk ? pins.k_rise : pins.c_rise;
  wire out_neg = pins.single_clk ? pins.kn_rise : pins.cn_rise;
  wire out_edge = out_pos || out_neg;
  // Starts only at the positive input edge.
  wire wr_start = pins.k_rise && !pins.write_port_sel_n && !wbusy;
  wire rd_start = pins.k_rise && !pins.read_port_sel_n && !rpend && !rout;
  // Beats taken on every input edge after the start.
  wire wr_beat = wbusy && edge_k;
  // Lane mask sampled on the same edge as the data.
  wire [BSP_DW-1:0] wmask = bsp_mask(pins.byte_write_sel_n);
  wire [BSP_DEPTH_BITS-1:0] widx = waddr[BSP_DEPTH_BITS-1:0];
  wire [BSP_DEPTH_BITS-1:0] ridx = raddr[BSP_DEPTH_BITS-1:0];
  wire [BSP_DW-1:0] old_w = arr[wbeat][widx];
  wire [BSP_DW-1:0] merged = (old_w & ~wmask) | (pins.wdata & wmask);
  // Forward a beat written this cycle to the same location.
  wire fwd = wr_beat && (widx == ridx) && (wbeat == rbeat);
  wire [BSP_DW-1:0] rd_word = fwd ? merged : arr[rbeat][ridx];
  // Latency: 1.5 cycles normally, 1 cycle with dll off.
  wire [2:0] lat = pins.dll_disable_n ? BSP_LAT_DLL : BSP_LAT_NODLL;

  // ----------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------
  // Address taken only when the write port is selected.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      waddr <= '0;
      wbeat <= BSP_BEAT_RST;
      wbusy <= 1'b0;
    end else if (wr_start) begin
      waddr <= pins.addr;
      wbeat <= BSP_BEAT_RST;
      wbusy <= 1'b1;
    end else if (wr_beat) begin
      wbeat <= 2'(wbeat + 1'b1);
      if (wbeat == 2'h3) wbusy <= 1'b0;
    end
  end

  // Array write, unselected lanes keep their contents.
  always_ff @(posedge mclk) begin
    if (wr_beat) arr[wbeat][widx] <= merged;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Pending read finishes even if the port is deselected.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      raddr <= '0;
      rwait <= '0;
      rpend <= 1'b0;
      rbeat <= BSP_BEAT_RST;
      rout <= 1'b0;
    end else if (rd_start) begin
      raddr <= pins.addr;
      // The output register spends the last edge, so count one edge less.
      rwait <= 3'(lat - 1'b1);
      rpend <= 1'b1;
    end else if (rpend && edge_k) begin
      rwait <= 3'(rwait - 1'b1);
      if (rwait == 3'h1) begin
        rpend <= 1'b0;
        rout <= 1'b1;
        rbeat <= BSP_BEAT_RST;
      end
    end else if (rout && out_edge) begin
      rbeat <= 2'(rbeat + 1'b1);
      if (rbeat == 2'h3) rout <= 1'b0;
    end
  end

  // Output register, tri-stated after the last beat.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
      oe_q <= 1'b0;
    end else if (rout && out_edge) begin
      rdata_q <= rd_word;
      oe_q <= 1'b1;
    end else if (!rout && out_pos) begin
      oe_q <= 1'b0;
    end
  end

  // Echo clocks toggle with the output edges and never stop.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) echo_q <= 2'h0;
    else if (out_pos) echo_q <= 2'h1;
    else if (out_neg) echo_q <= 2'h2;
  end

  assign pins.rdata = rdata_q;
  assign pins.rdata_oe = oe_q;
  assign pins.echo_clk_pair = echo_q;
endmodule : bsp_mem

// ===== rtl/bsp_ctrl.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Controller end: queues burst requests in a FIFO and plays them out.
// ------------------------------------------------------------------
module bsp_ctrl
  import bsp_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic single_clk,
  input wire logic dll_disable_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [BSP_AW-1:0] req_addr,
  input wire logic [BSP_DW*BSP_BURST-1:0] req_wdata,
  input wire logic [BSP_LANES*BSP_BURST-1:0] req_sel_n,
  output logic [BSP_DW-1:0] rd_data,
  output logic rd_valid,
  bsp_if.ctrl pins
);
  localparam int RW = 1 + BSP_AW + BSP_DW*BSP_BURST + BSP_LANES*BSP_BURST;
  logic phase; // Half-cycle phase: 0 gives k_rise, 1 gives kn_rise.
  bsp_state_t state; // Burst sequencer state.
  logic [2:0] beat; // Write beat counter.
  logic [RW-1:0] cur; // Request being played out.
  logic wsel_n, rsel_n; // Port selects.
  logic [BSP_AW-1:0] addr_q;
  logic [BSP_DW-1:0] wdata_q;
  logic [BSP_LANES-1:0] sel_q;
  logic [BSP_DW-1:0] rd_q;
  logic rdv_q;
  wire f_valid;
  wire [RW-1:0] f_data;
  // Take on the negative phase, so the select stands in the next k_rise cycle.
  wire take = f_valid && (state == BSP_IDLE) && phase;

  bsp_fifo #(.WIDTH(RW), .DEPTH(BSP_FIFO_DEPTH)) u_fifo (
    .mclk(mclk), .nrst(nrst),
    .in_valid(req_valid), .in_ready(req_ready),
    .in_data({req_write, req_addr, req_wdata, req_sel_n}),
    .out_valid(f_valid), .out_ready(take), .out_data(f_data)
  );

  wire cur_wr = cur[RW-1];
  wire [BSP_DW*BSP_BURST-1:0] cur_d = cur[BSP_LANES*BSP_BURST +: BSP_DW*BSP_BURST];
  wire [BSP_LANES*BSP_BURST-1:0] cur_s = cur[BSP_LANES*BSP_BURST-1:0];
  wire [1:0] bi = beat[1:0];

  // Clock phase divider: both edges alternate every mclk.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) phase <= 1'b0;
    else phase <= ~phase;
  end

  // Sequencer: select at K edge, then for writes only four beats of data with masks.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= BSP_IDLE;
      beat <= '0;
      cur <= '0;
      wsel_n <= 1'b1;
      rsel_n <= 1'b1;
      addr_q <= '0;
      wdata_q <= '0;
      sel_q <= '1;
    end else if (take) begin
      cur <= f_data;
      addr_q <= f_data[RW-2 -: BSP_AW];
      wsel_n <= ~f_data[RW-1];
      rsel_n <= f_data[RW-1];
      state <= f_data[RW-1] ? BSP_BUSY : BSP_IDLE;
      beat <= '0;
    end else begin
      wsel_n <= 1'b1;
      rsel_n <= 1'b1;
      if (state == BSP_BUSY) begin
        wdata_q <= cur_d[bi*BSP_DW +: BSP_DW];
        sel_q <= cur_s[bi*BSP_LANES +: BSP_LANES];
        beat <= 3'(beat + 1'b1);
        if (beat == 3'h3) state <= BSP_IDLE;
      end else sel_q <= '1;
    end
  end

  // Capture read beats while the memory drives the bus.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= '0;
      rdv_q <= 1'b0;
    end else begin
      rd_q <= pins.rdata;
      rdv_q <= pins.rdata_oe;
    end
  end

  assign pins.k_rise = !phase;
  assign pins.kn_rise = phase;
  assign pins.c_rise = !phase;
  assign pins.cn_rise = phase;
  assign pins.single_clk = single_clk;
  assign pins.dll_disable_n = dll_disable_n;
  assign pins.read_port_sel_n = rsel_n;
  assign pins.write_port_sel_n = wsel_n;
  assign pins.addr = addr_q;
  assign pins.wdata = wdata_q;
  assign pins.byte_write_sel_n = sel_q;
  assign rd_data = rd_q;
  assign rd_valid = rdv_q;
endmodule : bsp_ctrl

// ===== tb/bsp_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Pin-level checks on the link between controller and memory.
// ------------------------------------------------------------------
module bsp_assertions (
  input logic mclk,
  input logic nrst,
  input logic k_rise,
  input logic kn_rise,
  input logic c_rise,
  input logic cn_rise,
  input logic single_clk,
  input logic dll_disable_n,
  input logic read_port_sel_n,
  input logic write_port_sel_n,
  input logic rdata_oe,
  input logic [1:0] echo_clk_pair
);
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_phase_alt: assert property (k_rise |=> kn_rise && !k_rise)
    else $error("input edge phases do not alternate");
  a_phase_back: assert property (kn_rise |=> k_rise && !kn_rise)
    else $error("negative phase not followed by positive phase");
  a_wsel_on_k: assert property (!write_port_sel_n |-> k_rise)
    else $error("write select outside positive input edge");
  a_rsel_on_k: assert property (!read_port_sel_n |-> k_rise)
    else $error("read select outside positive input edge");
  // A write burst owns four edges; a new select inside it would be lost.
  a_write_gap: assert property (!write_port_sel_n |=> write_port_sel_n [*4])
    else $error("write select repeated inside a burst");
  a_read_lat: assert property ((!read_port_sel_n && dll_disable_n && !rdata_oe)
    |-> !rdata_oe [*3] ##[1:2] rdata_oe)
    else $error("read data late or early with dll on");
  a_dll_lat: assert property ((!read_port_sel_n && !dll_disable_n && !rdata_oe)
    |-> !rdata_oe [*2] ##[1:2] rdata_oe)
    else $error("read data late or early with dll off");
  // Four beats are driven, then the outputs float again.
  a_oe_four: assert property ($rose(rdata_oe) |-> rdata_oe [*4] ##[1:2] !rdata_oe)
    else $error("read burst not four beats then released");
  a_echo_pos: assert property ((single_clk ? k_rise : c_rise)
    |=> echo_clk_pair == 2'h1)
    else $error("echo pair wrong after positive edge");
  a_echo_neg: assert property ((single_clk ? kn_rise : cn_rise)
    |=> echo_clk_pair == 2'h2)
    else $error("echo pair wrong after negative edge");
endmodule : bsp_assertions

// ===== tb/separate_io_burst_sram_port_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Controller and memory face each other; the bench drives requests.
// ------------------------------------------------------------------
module separate_io_burst_sram_port_tb;
  import bsp_pkg::*;
  logic mclk = 1'b0; // System clock, 100 MHz.
  logic nrst = 1'b0; // Reset, active low.
  logic single_clk = 1'b0; // Output clock source select.
  logic dll_disable_n = 1'b1; // Dll mode select, active low.
  logic req_valid = 1'b0; // Request strobe.
  logic req_ready; // Request accepted.
  logic req_write = 1'b0; // Burst direction.
  logic [BSP_AW-1:0] req_addr = '0; // Burst address.
  logic [BSP_DW*4-1:0] req_wdata = '0; // Four write beats.
  logic [BSP_LANES*4-1:0] req_sel_n = '1; // Lane selects per beat.
  logic [BSP_DW-1:0] rd_data; // Returned beat.
  logic rd_valid; // Beat valid.
  logic [BSP_DW*4-1:0] ref_mem [0:63]; // Expected contents.
  logic full_seen = 1'b0; // Set once the queue refused a request.
  int num_errors = 0;
  int compares = 0;

  bsp_if bif ();
  bsp_ctrl i_bsp_ctrl (.mclk(mclk), .nrst(nrst), .single_clk(single_clk),
    .dll_disable_n(dll_disable_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_sel_n(req_sel_n), .rd_data(rd_data), .rd_valid(rd_valid), .pins(bif.ctrl));
  bsp_mem i_bsp_mem (.mclk(mclk), .nrst(nrst), .pins(bif.mem));
  bsp_assertions i_bsp_assertions (.mclk(mclk), .nrst(nrst), .k_rise(bif.k_rise),
    .kn_rise(bif.kn_rise), .c_rise(bif.c_rise), .cn_rise(bif.cn_rise),
    .single_clk(bif.single_clk), .dll_disable_n(bif.dll_disable_n),
    .read_port_sel_n(bif.read_port_sel_n), .write_port_sel_n(bif.write_port_sel_n),
    .rdata_oe(bif.rdata_oe), .echo_clk_pair(bif.echo_clk_pair));

  // Free-running clock.
  always #5 mclk = ~mclk;

  // Compare one value and report a difference at once.
  task automatic check(input logic [BSP_DW-1:0] seen, input logic [BSP_DW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Hold the request until ready is sampled high on a rising edge.
  task automatic send(input logic w, input int a, input logic [BSP_DW*4-1:0] d,
                      input logic [BSP_LANES*4-1:0] s);
    int n;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= BSP_AW'(a);
    req_wdata <= d;
    req_sel_n <= s;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (req_ready !== 1'b1) full_seen = 1'b1;
    end while (req_ready !== 1'b1 && n < 200);
    if (n >= 200) num_errors++;
    req_valid <= 1'b0;
  endtask : send

  // Write a burst and merge the selected lanes into the expectation.
  task automatic wr(input int a, input logic [BSP_DW*4-1:0] d,
                    input logic [BSP_LANES*4-1:0] s);
    send(1'b1, a, d, s);
    for (int i = 0; i < BSP_LANES * 4; i++) begin
      if (!s[i]) ref_mem[a][i*BSP_LANE_W +: BSP_LANE_W] = d[i*BSP_LANE_W +: BSP_LANE_W];
    end
  endtask : wr

  // Read a burst and compare its four beats in array order.
  task automatic rdchk(input int a);
    int n;
    send(1'b0, a, '0, '1);
    n = 0;
    while (rd_valid !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) num_errors++;
    for (int b = 0; b < 4; b++) begin
      check(rd_data, ref_mem[a][b*BSP_DW +: BSP_DW]);
      @(posedge mclk);
    end
  endtask : rdchk

  // Four distinct beats, so a swapped beat order shows up.
  function automatic logic [BSP_DW*4-1:0] pat(input int a);
    return {36'hD00000003, 36'hC00000002, 36'hB00000001, 36'hA00000000} ^ {4{BSP_DW'(a)}};
  endfunction : pat

  // Print the counts and the verdict, then stop.
  task automatic end_sim;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Cut a hang short; the whole sequence needs a few hundred cycles.
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    wr(5, pat(5), 16'h0000);
    rdchk(5);
    $display("test 1 full burst done");
    // Each beat masks other lanes, so per-beat sampling is needed.
    wr(5, ~pat(5), 16'hA5C3);
    rdchk(5);
    $display("test 2 lane masks done");
    wr(6, pat(6), 16'h0000);
    rdchk(5);
    rdchk(6);
    $display("test 3 address isolation done");
    dll_disable_n <= 1'b0;
    rdchk(6);
    dll_disable_n <= 1'b1;
    single_clk <= 1'b1;
    rdchk(5);
    single_clk <= 1'b0;
    $display("test 4 clock modes done");
    // Pushes outrun the bursts, so the queue must refuse at some point.
    for (int i = 8; i < 24; i++) wr(i, pat(i), 16'h0000);
    check(BSP_DW'(full_seen), BSP_DW'(1));
    for (int i = 8; i < 24; i++) rdchk(i);
    $display("test 5 queue fill and drain done");
    end_sim();
  end
endmodule : separate_io_burst_sram_port_tb
